// ### sarq_pkg.sv
// Purpose: shared constants and types of the converter sequencer
// Assumes: pclk stands in for the E clock; APB word addresses
// Notes: a register's byte address is four times its index
// Operation
// - mux routes one of sixteen sources
// - eight comparisons per conversion, MSB first
// - finished approximation copied to slot result
// - four readable 8-bit result registers
// - result updates avoid processor read cycles
// - sequences of four, repeat or stop
// - done flag after fourth result stored
// - control write starts sequence one cycle later
// - low reference gives 00, high gives FF
// - power-up bit enables converter and pump
// - clock select picks RC or E clock
// - E clock mode synchronous, RC mode asynchronous
// - input switch closed 12 cycles per conversion
// - protected bits write once within 64 cycles
// - special modes leave protected bits writable
// - edge select: falling edge or low level
// - stop exit delay 4000 or four cycles
// - forced monitor sticky until reset
// - control write clears flag, restarts sequence
// - continuous round robin, else once and halt
// - single channel converted four times in order
// - multi channel uses upper bits as group
package sarq_pkg;
  // register indices (byte address = index * 4)
  localparam logic [7:0] IDX_CTL = 8'h30;
  localparam logic [7:0] IDX_RES0 = 8'h31;
  localparam logic [7:0] IDX_OPT = 8'h39;
  localparam logic [7:0] OPT_RESET = 8'h10;
  // option bit positions
  localparam int OPT_CONVERTER_POWER_UP = 7;
  localparam int OPT_CONVERTER_CLOCK_SOURCE = 6;
  localparam int OPT_IRQ_EDGE_SELECT = 5;
  localparam int OPT_DLY = 4;
  localparam int OPT_CME = 3;
  localparam int OPT_CLOCK_MONITOR_FORCE = 2;
  // control bit positions
  localparam int CTL_DONE = 7;
  localparam int CTL_SCAN = 5;
  localparam int CTL_MULTI_CHANNEL_SELECT = 4;
  // timing counts: sample and step in pclk cycles or rc ticks, the rest in pclk cycles
  localparam logic [3:0] SAMPLE_CYCLES = 4'hC;
  localparam logic [3:0] STEP_CYCLES = 4'h4;
  localparam logic [6:0] PROT_WINDOW = 7'h40;
  localparam logic [11:0] STOP_DELAY_LONG = 12'hFA0;
  localparam logic [11:0] STOP_DELAY_SHORT = 12'h004;

  // sequencer states, gray from idle through store
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_COMPARE = 3'h2,
    ST_STORE = 3'h6
  } sarq_state_e;

  // whole state of the sequencer
  typedef struct packed {
    sarq_state_e st;
    logic [1:0] slot;
    logic [2:0] bit_idx;
    logic [3:0] cnt;
    logic [7:0] sar;
    logic [3:0][7:0] res;
    logic done;
    logic scan;
    logic multi_channel_select;
    logic [3:0] chan;
    logic [7:0] opt;
    logic prot_used;
    logic [6:0] por_cnt;
    logic [2:0] comp_sync;
    logic [2:0] rc_sync;
    logic [1:0] spec_sync;
    logic [2:0] wake_sync;
    logic [11:0] stop_cnt;
    logic stopping;
    logic resume;
    logic [3:0] mux_sel;
    logic switch_on;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } sarq_state_s;
endpackage : sarq_pkg

// ### sarq_top.sv
// Purpose: APB-facing digital control of an 8-bit SAR converter
// Assumes: comparator, RC tick, wake and mode straps are async pins
// Notes: all outputs but clock_monitor_on come straight from the state register; it is an OR of two of its bits
//
// The APB register port was left to the implementer.
module sarq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comp_in,
  input wire logic rc_tick,
  input wire logic special_mode,
  input wire logic stop_wake,
  output logic [3:0] mux_sel,
  output logic sample_switch,
  output logic [7:0] dac_code,
  output logic converter_enable,
  output logic rc_clock_sel,
  output logic irq_edge_select,
  output logic clock_monitor_on,
  output logic [1:0] watchdog_rate,
  output logic cpu_resume
);
  sarq_pkg::sarq_state_s q_reg; // registered state
  sarq_pkg::sarq_state_s q_next; // next state

  ////////////////////////////////////////////////////////////////////
  // address decode shared by read and write paths
  function automatic logic [3:0] dec_addr(input logic [31:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    dec_addr = 4'h0;
    if (a[31:10] != 22'h0 || a[1:0] != 2'h0) begin
      dec_addr = 4'h0; // unmapped
    end else if (idx == sarq_pkg::IDX_CTL) begin
      dec_addr = 4'h1;
    end else if (idx == sarq_pkg::IDX_OPT) begin
      dec_addr = 4'h2;
    end else if (idx >= sarq_pkg::IDX_RES0 && idx < sarq_pkg::IDX_RES0 + 8'h04) begin
      dec_addr = {2'h3, 2'(idx - sarq_pkg::IDX_RES0)}; // results 0..3
    end
  endfunction : dec_addr

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    logic [3:0] sel;
    logic bus_read;
    logic wr_fire;
    logic adv;
    logic prot_ok;
    logic [7:0] w;
    sel = dec_addr(paddr);
    prot_ok = 1'b0;
    bus_read = psel && !pwrite;
    wr_fire = psel && penable && pwrite && q_reg.pready;
    w = pwdata[7:0];
    q_next = q_reg;
    // two-flop synchronisers; second stage read, rc tick and wake also read a third stage for edge detection
    q_next.comp_sync = {q_reg.comp_sync[1:0], comp_in};
    q_next.rc_sync = {q_reg.rc_sync[1:0], rc_tick};
    q_next.spec_sync = {q_reg.spec_sync[0], special_mode};
    q_next.wake_sync = {q_reg.wake_sync[1:0], stop_wake};
    // rc mode steps on rc ticks, e clock mode on every edge
    adv = q_reg.opt[sarq_pkg::OPT_CONVERTER_CLOCK_SOURCE] ? (q_reg.rc_sync[1] && !q_reg.rc_sync[2]) : 1'b1;
    if (q_reg.por_cnt != sarq_pkg::PROT_WINDOW) begin
      q_next.por_cnt = 7'(q_reg.por_cnt + 7'h1);
    end
    // apb: one wait cycle, then answer from flops
    q_next.pready = psel && penable && !q_reg.pready;
    q_next.pslverr = psel && penable && !q_reg.pready && (sel == 4'h0);
    if (psel && penable && !q_reg.pready) begin
      case (sel)
        4'h1: q_next.prdata = {24'h0, q_reg.done, 1'b0, q_reg.scan, q_reg.multi_channel_select, q_reg.chan};
        4'h2: q_next.prdata = {24'h0, q_reg.opt};
        4'hC, 4'hD, 4'hE, 4'hF: q_next.prdata = {24'h0, q_reg.res[sel[1:0]]};
        default: q_next.prdata = 32'h0;
      endcase
    end
    // sequencer
    case (q_reg.st)
      sarq_pkg::ST_IDLE: begin
        q_next.switch_on = 1'b0;
      end
      sarq_pkg::ST_START: begin
        q_next.st = sarq_pkg::ST_SAMPLE;
        q_next.slot = 2'h0;
        q_next.cnt = 4'h0;
        q_next.switch_on = 1'b1;
      end
      sarq_pkg::ST_SAMPLE: begin
        if (adv) begin
          if (q_reg.cnt == sarq_pkg::SAMPLE_CYCLES - 4'h1) begin
            q_next.st = sarq_pkg::ST_COMPARE;
            q_next.switch_on = 1'b0;
            q_next.cnt = 4'h0;
            q_next.bit_idx = 3'h7;
            q_next.sar = 8'h80;
          end else begin
            q_next.cnt = 4'(q_reg.cnt + 4'h1);
          end
        end
      end
      sarq_pkg::ST_COMPARE: begin
        // trial held a few cycles so the synchronised comparator settles
        if (adv) begin
          if (q_reg.cnt == sarq_pkg::STEP_CYCLES - 4'h1) begin
            q_next.cnt = 4'h0;
            // comparator low means input below trial: drop the bit
            if (!q_reg.comp_sync[1]) begin
              q_next.sar[q_reg.bit_idx] = 1'b0;
            end
            if (q_reg.bit_idx == 3'h0) begin
              q_next.st = sarq_pkg::ST_STORE;
            end else begin
              q_next.bit_idx = 3'(q_reg.bit_idx - 3'h1);
              q_next.sar[q_reg.bit_idx - 3'h1] = 1'b1;
            end
          end else begin
            q_next.cnt = 4'(q_reg.cnt + 4'h1);
          end
        end
      end
      sarq_pkg::ST_STORE: begin
        // store deferred while a read is on the bus
        if (!bus_read) begin
          q_next.res[q_reg.slot] = q_reg.sar;
          q_next.slot = 2'(q_reg.slot + 2'h1);
          q_next.cnt = 4'h0;
          if (q_reg.slot == 2'h3) begin
            q_next.done = 1'b1;
            if (q_reg.scan) begin
              q_next.st = sarq_pkg::ST_SAMPLE;
              q_next.switch_on = 1'b1;
            end else begin
              q_next.st = sarq_pkg::ST_IDLE;
            end
          end else begin
            q_next.st = sarq_pkg::ST_SAMPLE;
            q_next.switch_on = 1'b1;
          end
        end
      end
      default: begin
        q_next.st = sarq_pkg::ST_IDLE;
      end
    endcase
    // channel: single uses all four bits, multi uses group plus slot
    q_next.mux_sel = q_next.multi_channel_select ? {q_next.chan[3:2], q_next.slot} : q_next.chan;
    // register writes take effect at the pready edge
    if (wr_fire && sel == 4'h1) begin
      q_next.scan = w[sarq_pkg::CTL_SCAN];
      q_next.multi_channel_select = w[sarq_pkg::CTL_MULTI_CHANNEL_SELECT];
      q_next.chan = w[3:0];
      q_next.done = 1'b0;
      q_next.switch_on = 1'b0;
      q_next.st = q_reg.opt[sarq_pkg::OPT_CONVERTER_POWER_UP] ? sarq_pkg::ST_START : sarq_pkg::ST_IDLE;
      q_next.mux_sel = w[sarq_pkg::CTL_MULTI_CHANNEL_SELECT] ? {w[3:2], 2'h0} : w[3:0];
    end
    if (wr_fire && sel == 4'h2) begin
      q_next.opt[sarq_pkg::OPT_CONVERTER_POWER_UP] = w[sarq_pkg::OPT_CONVERTER_POWER_UP];
      q_next.opt[sarq_pkg::OPT_CONVERTER_CLOCK_SOURCE] = w[sarq_pkg::OPT_CONVERTER_CLOCK_SOURCE];
      q_next.opt[sarq_pkg::OPT_CME] = w[sarq_pkg::OPT_CME];
      prot_ok = q_reg.spec_sync[1] ||
                (!q_reg.prot_used && q_reg.por_cnt != sarq_pkg::PROT_WINDOW);
      if (prot_ok) begin
        q_next.prot_used = 1'b1;
        q_next.opt[sarq_pkg::OPT_IRQ_EDGE_SELECT] = w[sarq_pkg::OPT_IRQ_EDGE_SELECT];
        q_next.opt[sarq_pkg::OPT_DLY] = w[sarq_pkg::OPT_DLY];
        q_next.opt[1:0] = w[1:0];
        // forced monitor can be set but never cleared before reset
        q_next.opt[sarq_pkg::OPT_CLOCK_MONITOR_FORCE] = q_reg.opt[sarq_pkg::OPT_CLOCK_MONITOR_FORCE] | w[sarq_pkg::OPT_CLOCK_MONITOR_FORCE];
      end
    end
    // powering down stops any conversion and opens the input switch
    if (!q_next.opt[sarq_pkg::OPT_CONVERTER_POWER_UP]) begin
      q_next.st = sarq_pkg::ST_IDLE;
      q_next.switch_on = 1'b0;
    end
    // stop-mode exit delay
    q_next.resume = 1'b0;
    if (q_reg.wake_sync[1] && !q_reg.wake_sync[2] && !q_reg.stopping) begin
      q_next.stopping = 1'b1;
      q_next.stop_cnt = q_reg.opt[sarq_pkg::OPT_DLY] ?
                        sarq_pkg::STOP_DELAY_LONG : sarq_pkg::STOP_DELAY_SHORT;
    end else if (q_reg.stopping) begin
      if (q_reg.stop_cnt == 12'h001) begin
        q_next.stopping = 1'b0;
        q_next.resume = 1'b1;
      end
      q_next.stop_cnt = 12'(q_reg.stop_cnt - 12'h001);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= '0;
      q_reg.opt <= sarq_pkg::OPT_RESET;
    end else begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from flops, clock_monitor_on an OR of two
  assign prdata = q_reg.prdata;
  assign pready = q_reg.pready;
  assign pslverr = q_reg.pslverr;
  assign mux_sel = q_reg.mux_sel;
  assign sample_switch = q_reg.switch_on;
  assign dac_code = q_reg.sar;
  assign converter_enable = q_reg.opt[sarq_pkg::OPT_CONVERTER_POWER_UP];
  assign rc_clock_sel = q_reg.opt[sarq_pkg::OPT_CONVERTER_CLOCK_SOURCE];
  assign irq_edge_select = q_reg.opt[sarq_pkg::OPT_IRQ_EDGE_SELECT];
  assign clock_monitor_on = q_reg.opt[sarq_pkg::OPT_CLOCK_MONITOR_FORCE] | q_reg.opt[sarq_pkg::OPT_CME];
  assign watchdog_rate = q_reg.opt[1:0];
  assign cpu_resume = q_reg.resume;
endmodule : sarq_top

// ### sarq_properties.sv
// Purpose: port-level checks of the converter sequencer
// Assumes: pclk clocks everything, presetn async low
// Notes: bound to sarq_top below the module
module sarq_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sample_switch,
  input wire logic rc_clock_sel,
  input wire logic converter_enable,
  input wire logic [7:0] dac_code,
  input wire logic [3:0] mux_sel,
  input wire logic [1:0] watchdog_rate
);
  logic [4:0] sw_run; // cycles the input switch has been closed
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // run length counter, cleared when the switch opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_run <= 5'h00;
    end else begin
      sw_run <= sample_switch ? sw_run + 5'h01 : 5'h00;
    end
  end
  a_ready_one_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // a register write may cut the sample short on purpose, so such falls are not checked
  a_switch_twelve: assert property ($fell(sample_switch) && !rc_clock_sel && converter_enable &&
    !$past(pready && pwrite) |-> sw_run == 5'h0C)
    else $error("sample interval not 12 cycles");
  a_off_no_sample: assert property (!converter_enable && $past(!converter_enable) |-> !sample_switch)
    else $error("sampling while powered down");
  a_msb_first: assert property ($fell(sample_switch) && converter_enable &&
    !$past(pready && pwrite) |-> ##[0:2] dac_code == 8'h80)
    else $error("first trial is not the top bit");
  a_mux_held: assert property (sample_switch && $past(sample_switch) |-> $stable(mux_sel))
    else $error("channel moved while sampling");
  a_rate_on_write: assert property ($changed(watchdog_rate) |-> $past(pready && pwrite))
    else $error("protected bits changed without write");
endmodule : sarq_properties
bind sarq_top sarq_properties sarq_properties_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .sample_switch(sample_switch), .rc_clock_sel(rc_clock_sel),
  .converter_enable(converter_enable), .dac_code(dac_code), .mux_sel(mux_sel),
  .watchdog_rate(watchdog_rate));

// ### sarq_analog.sv
// Purpose: analog side model, channel k sits at code 8'h11 * k
// Assumes: comparator answers at once, the design syncs it
// Notes: powered down, the comparator output is noise
module sarq_analog (
  input wire logic pclk,
  input wire logic [3:0] mux_sel,
  input wire logic [7:0] dac_code,
  input wire logic sample_switch,
  input wire logic converter_enable,
  output logic comp_in
);
  logic [7:0] held = 8'h00; // charge caught on the array
  logic junk = 1'b0; // toggles so a dead comparator never looks settled
  // sample only while the switch is closed
  always_ff @(posedge pclk) begin
    junk <= ~junk;
    if (sample_switch) begin
      held <= 8'h11 * {4'h0, mux_sel};
    end
  end
  assign comp_in = converter_enable ? (held >= dac_code) : junk;
endmodule : sarq_analog

// ### sar_adc_sequencer_bench.sv
// Purpose: register-level test of the converter sequencer
// Assumes: APB slave with one wait state, 40 MHz pclk
// Notes: expected codes follow the analog model levels
module sar_adc_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
  logic pready, pslverr, comp_in, stop_wake = 1'b0, err;
  logic special_mode = 1'b0; // strap, raised only for the unlocked-write test
  logic [3:0] mux_sel;
  logic [7:0] dac_code;
  logic sample_switch, converter_enable, rc_clock_sel, irq_edge_select;
  logic clock_monitor_on, cpu_resume;
  logic [1:0] watchdog_rate;
  int fail_count = 0, checked = 0, n;
  sarq_top sarq_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comp_in(comp_in), .rc_tick(1'b0), .special_mode(special_mode),
    .stop_wake(stop_wake), .mux_sel(mux_sel), .sample_switch(sample_switch),
    .dac_code(dac_code), .converter_enable(converter_enable), .rc_clock_sel(rc_clock_sel),
    .irq_edge_select(irq_edge_select), .clock_monitor_on(clock_monitor_on),
    .watchdog_rate(watchdog_rate), .cpu_resume(cpu_resume));
  sarq_analog sarq_analog_inst (.pclk(pclk), .mux_sel(mux_sel), .dac_code(dac_code),
    .sample_switch(sample_switch), .converter_enable(converter_enable), .comp_in(comp_in));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : check
  // one APB transfer; an idle cycle follows so psel is never set twice
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    int m;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h0, i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    m = 0;
    do begin
      @(posedge pclk);
      m++;
    end while (pready !== 1'b1 && m < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      stop_test();
    end
    @(posedge pclk);
  endtask : apb
  // start a sequence, poll for done, compare all four slots
  task automatic run(input logic [7:0] c, input logic [7:0] e0, input logic [7:0] de);
    apb(1'b1, sarq_pkg::IDX_CTL, c);
    q = 32'h0;
    for (n = 0; n < 100 && q[7] !== 1'b1; n++) begin
      repeat (20) @(posedge pclk);
      apb(1'b0, sarq_pkg::IDX_CTL, 8'h00);
    end
    check("control", {24'h0, c | 8'h80}, q);
    for (n = 0; n < 4; n++) begin
      apb(1'b0, sarq_pkg::IDX_RES0 + 8'(n), 8'h00);
      check("result", {24'h0, e0 + de * 8'(n)}, q);
    end
  endtask : run
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sarq_pkg::IDX_OPT, 8'h00);
    check("option", 32'h10, q);
    apb(1'b1, sarq_pkg::IDX_OPT, 8'h02);
    apb(1'b1, sarq_pkg::IDX_CTL, 8'h0F);
    repeat (300) @(posedge pclk);
    apb(1'b0, sarq_pkg::IDX_CTL, 8'h00);
    check("control", 32'h0F, q);
    apb(1'b1, sarq_pkg::IDX_OPT, 8'hAD);
    apb(1'b0, sarq_pkg::IDX_OPT, 8'h00);
    check("option", 32'h8A, q);
    check("rate", 32'h2, 32'(watchdog_rate));
    check("enable", 32'h1, 32'(converter_enable));
    check("monitor", 32'h1, 32'(clock_monitor_on));
    special_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, sarq_pkg::IDX_OPT, 8'h81);
    apb(1'b0, sarq_pkg::IDX_OPT, 8'h00);
    check("option", 32'h81, q);
    check("monitor", 32'h0, 32'(clock_monitor_on));
    check("edge", 32'h0, 32'(irq_edge_select));
    special_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    repeat (4000) @(posedge pclk);
    stop_wake <= 1'b1;
    for (n = 0; n < 12 && cpu_resume !== 1'b1; n++) @(posedge pclk);
    check("resume", 32'h1, 32'(cpu_resume));
    stop_wake <= 1'b0;
    run(8'h0F, 8'hFF, 8'h00);
    run(8'h17, 8'h44, 8'h11);
    run(8'h00, 8'h00, 8'h00);
    apb(1'b1, sarq_pkg::IDX_CTL, 8'h0F);
    repeat (30) @(posedge pclk);
    apb(1'b0, sarq_pkg::IDX_CTL, 8'h00);
    check("control", 32'h0F, q);
    run(8'h24, 8'h44, 8'h00);
    repeat (400) @(posedge pclk);
    apb(1'b0, sarq_pkg::IDX_CTL, 8'h00);
    check("control", 32'hA4, q);
    apb(1'b0, 8'h3F, 8'h00);
    check("slverr", 32'h1, 32'(err));
    stop_test();
  end
endmodule : sar_adc_sequencer_bench
